/* rtl/lspl_pkg.sv */
// Package for the low-speed PLL lane configuration block
package lspl_pkg;
    localparam logic [15:0] LANE_CFG_OFFSET = 16'h0006;
    localparam logic [15:0] LANE_B_OFFSET = 16'h0007;
    localparam logic [15:0] LANE_C_OFFSET = 16'h0008;
    localparam logic [15:0] CHAN_A_OFFSET = 16'h0009;
    localparam logic [4:0] DEV_ADDR = 5'h1e;
    localparam logic [15:0] LANE_CFG_RESET = 16'hf115;
    localparam logic [15:0] LANE_B_RESET = 16'hdc04;
    localparam logic [15:0] LANE_C_RESET = 16'h0000;
    localparam logic [15:0] CHAN_A_RESET = 16'h0000;
    localparam int SEL_HI = 15;
    localparam int SEL_LO = 12;
    localparam int RSVA_HI = 11;
    localparam int RSVA_LO = 10;
    localparam int BW_HI = 9;
    localparam int BW_LO = 8;
    localparam int RSVB_HI = 7;
    localparam int RSVB_LO = 5;
    localparam int PLL_ON_BIT = 4;
    localparam int MPY_HI = 3;
    localparam int MPY_LO = 0;
    localparam int NUM_LANES = 4;
    localparam logic [1:0] BW_NO_CLEANER = 2'h1;
    localparam logic [1:0] BW_WITH_CLEANER = 2'h2;

    typedef struct packed {
        logic [3:0] lane_write_select;
        logic [1:0] rsv_a;
        logic [1:0] lowspeed_pll_loop_bw;
        logic [2:0] rsv_b;
        logic lowspeed_pll_on;
        logic [3:0] lowspeed_pll_multiplier;
    } lspl_cfg_t;

    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } lspl_req_t;
endpackage : lspl_pkg

/* rtl/lspl_lane_regs.sv */
// Per-lane copies of one shared lane control register
`timescale 1ns/100ps
`default_nettype none
module lspl_lane_regs #(
    parameter int LANES = 4,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [LANES-1:0] lane_mask,
    input wire logic [15:0] wdata,
    input wire logic [LANES-1:0] rd_sel,
    output logic [15:0] rdata,
    output logic [LANES*16-1:0] lane_values
);
    logic [15:0] copy_reg [LANES];
    logic [15:0] copy_next [LANES];

    // RL12: one copy per lane
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            always_comb begin
                copy_next[g] = copy_reg[g];
                // RL2: masked lane write
                if (wr_en && lane_mask[g]) begin
                    copy_next[g] = wdata;
                end
            end
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    copy_reg[g] <= RESET_VAL;
                end else begin
                    copy_reg[g] <= copy_next[g];
                end
            end
            assign lane_values[g*16 +: 16] = copy_reg[g];
        end
    endgenerate

    // RL3: one-hot read mux
    always_comb begin
        rdata = 16'h0000;
        for (int i = 0; i < LANES; i++) begin
            if (rd_sel[i]) begin
                rdata = rdata | copy_reg[i];
            end
        end
    end
endmodule : lspl_lane_regs
`default_nettype wire

/* rtl/lspl_lane_cfg.sv */
// Low-speed PLL and lane select configuration register bank
//
// Operation
// RL1: Bits 15:12 select lanes three to zero; all set after reset.
// RL2: Shared lane register writes touch only lanes whose select bit is set.
// RL3: Shared lane register reads return the single one-hot selected lane.
// RL4: Controller ignores readback unless the select holds exactly one bit.
// RL5: Loop bandwidth bits 9:8 reset to 01; 10 with cleaner PLL.
// RL6: Bit 4 enables the low-speed PLL; resets to one.
// RL7: PLL forced off by powerdown pin low or global powerdown bit.
// RL8: Bits 3:0 hold PLL multiplier code, reset 0101.
// RL9: Reserved bits 11:10 and 7:5 are stored read/write, reset zero.
// RL10: Multiplier codes map to fixed factors; other codes reserved.
// RL11: Register at offset 0x0006, device 0x1e, reads 0xf115 after reset.
// RL12: Each shared lane register has four copies gated by select mask.
`timescale 1ns/100ps
`default_nettype none
module lspl_lane_cfg #(
    parameter int LANES = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic req_valid,
    input wire lspl_pkg::lspl_req_t req,
    input wire logic [4:0] req_dev,
    input wire logic transceiver_powerdown_n,
    input wire logic global_powerdown,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic lowspeed_pll_active,
    output logic [1:0] lowspeed_pll_loop_bw,
    output logic [3:0] lowspeed_pll_multiplier,
    output logic multiplier_reserved,
    output logic [LANES*16-1:0] lane_b_values,
    output logic [LANES*16-1:0] lane_c_values,
    output logic [LANES*16-1:0] chan_a_values
);
    lspl_pkg::lspl_cfg_t cfg_reg, cfg_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [15:0] rsp_rdata_reg, rsp_rdata_next;
    logic pll_active_reg, pll_active_next;
    logic mpy_rsv_reg, mpy_rsv_next;
    logic pd_n_meta_reg, pd_n_sync_reg;
    logic hit;
    logic wr_b, wr_c, wr_a;
    logic [15:0] rd_b, rd_c, rd_a;
    logic [LANES*16-1:0] b_vals, c_vals, a_vals;

    // RL10: reserved multiplier codes
    function automatic logic mpy_is_reserved(input logic [3:0] code);
        case (code)
            4'h3, 4'hb, 4'hc, 4'hf: mpy_is_reserved = 1'b1;
            default: mpy_is_reserved = 1'b0;
        endcase
    endfunction : mpy_is_reserved

    function automatic logic is_write(input logic v, input lspl_pkg::lspl_req_t r,
                                      input logic h, input logic [15:0] off);
        is_write = v && h && r.wr && (r.addr == off);
    endfunction : is_write

    // RL11: device address decode
    assign hit = (req_dev == lspl_pkg::DEV_ADDR);
    assign wr_b = is_write(req_valid, req, hit, lspl_pkg::LANE_B_OFFSET);
    assign wr_c = is_write(req_valid, req, hit, lspl_pkg::LANE_C_OFFSET);
    assign wr_a = is_write(req_valid, req, hit, lspl_pkg::CHAN_A_OFFSET);

    lspl_lane_regs #(.LANES(LANES), .RESET_VAL(lspl_pkg::LANE_B_RESET)) u_lane_b (
        .clock(clock), .resetn(resetn), .wr_en(wr_b),
        .lane_mask(cfg_reg.lane_write_select), .wdata(req.wdata),
        .rd_sel(cfg_reg.lane_write_select), .rdata(rd_b), .lane_values(b_vals)
    );
    lspl_lane_regs #(.LANES(LANES), .RESET_VAL(lspl_pkg::LANE_C_RESET)) u_lane_c (
        .clock(clock), .resetn(resetn), .wr_en(wr_c),
        .lane_mask(cfg_reg.lane_write_select), .wdata(req.wdata),
        .rd_sel(cfg_reg.lane_write_select), .rdata(rd_c), .lane_values(c_vals)
    );
    lspl_lane_regs #(.LANES(LANES), .RESET_VAL(lspl_pkg::CHAN_A_RESET)) u_chan_a (
        .clock(clock), .resetn(resetn), .wr_en(wr_a),
        .lane_mask(cfg_reg.lane_write_select), .wdata(req.wdata),
        .rd_sel(cfg_reg.lane_write_select), .rdata(rd_a), .lane_values(a_vals)
    );

    always_comb begin
        cfg_next = cfg_reg;
        rsp_valid_next = 1'b0;
        rsp_rdata_next = rsp_rdata_reg;
        // RL1: writes to the config register
        if (is_write(req_valid, req, hit, lspl_pkg::LANE_CFG_OFFSET)) begin
            // RL9: reserved bits kept as storage
            cfg_next = lspl_pkg::lspl_cfg_t'(req.wdata);
        end
        if (req_valid && hit && !req.wr) begin
            rsp_valid_next = 1'b1;
            // RL3: lane readback selection
            unique case (req.addr)
                lspl_pkg::LANE_CFG_OFFSET: rsp_rdata_next = 16'(cfg_reg);
                lspl_pkg::LANE_B_OFFSET: rsp_rdata_next = rd_b;
                lspl_pkg::LANE_C_OFFSET: rsp_rdata_next = rd_c;
                lspl_pkg::CHAN_A_OFFSET: rsp_rdata_next = rd_a;
                default: rsp_rdata_next = 16'h0000;
            endcase
        end
        // RL7: forced PLL off
        pll_active_next = cfg_reg.lowspeed_pll_on && pd_n_sync_reg && !global_powerdown;
        // Flag follows the stored code in the same cycle
        mpy_rsv_next = mpy_is_reserved(cfg_next.lowspeed_pll_multiplier);
    end

    always_ff @(posedge clock) begin
        pd_n_meta_reg <= transceiver_powerdown_n;
        pd_n_sync_reg <= pd_n_meta_reg;
        if (!resetn) begin
            // RL11: reset value 0xf115
            cfg_reg <= lspl_pkg::lspl_cfg_t'(lspl_pkg::LANE_CFG_RESET);
            rsp_valid_reg <= 1'b0;
            rsp_rdata_reg <= 16'h0000;
            pll_active_reg <= 1'b0;
            mpy_rsv_reg <= 1'b0;
            lane_b_values <= {LANES{lspl_pkg::LANE_B_RESET}};
            lane_c_values <= {LANES{lspl_pkg::LANE_C_RESET}};
            chan_a_values <= {LANES{lspl_pkg::CHAN_A_RESET}};
        end else begin
            cfg_reg <= cfg_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_rdata_reg <= rsp_rdata_next;
            pll_active_reg <= pll_active_next;
            mpy_rsv_reg <= mpy_rsv_next;
            lane_b_values <= b_vals;
            lane_c_values <= c_vals;
            chan_a_values <= a_vals;
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rsp_rdata_reg;
    // RL6: PLL enable output
    assign lowspeed_pll_active = pll_active_reg;
    // RL5: loop bandwidth output
    assign lowspeed_pll_loop_bw = cfg_reg.lowspeed_pll_loop_bw;
    // RL8: multiplier output
    assign lowspeed_pll_multiplier = cfg_reg.lowspeed_pll_multiplier;
    assign multiplier_reserved = mpy_rsv_reg;
endmodule : lspl_lane_cfg
`default_nettype wire

/* test/lspl_lane_cfg_asserts.sv */
// Checker for the lane configuration block
`timescale 1ns/100ps
`default_nettype none
module lspl_lane_cfg_chk #(
    parameter int LANES = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic req_valid,
    input wire lspl_pkg::lspl_req_t req,
    input wire logic [4:0] req_dev,
    input wire logic transceiver_powerdown_n,
    input wire logic global_powerdown,
    input wire logic rsp_valid,
    input wire logic [15:0] rsp_rdata,
    input wire logic lowspeed_pll_active,
    input wire logic [1:0] lowspeed_pll_loop_bw,
    input wire logic [3:0] lowspeed_pll_multiplier,
    input wire logic multiplier_reserved,
    input wire logic [LANES*16-1:0] lane_b_values
);
    logic rd_take;
    logic wr_any;
    assign rd_take = req_valid && !req.wr && req_dev == lspl_pkg::DEV_ADDR;
    assign wr_any = req_valid && req.wr;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);
    read_answer_a: assert property (rd_take |=> rsp_valid)
        else $error("read not answered");
    no_extra_a: assert property (!rd_take |=> !rsp_valid)
        else $error("answer without read");
    data_hold_a: assert property (!rsp_valid |-> $stable(rsp_rdata))
        else $error("read data moved");
    gdown_off_a: assert property (global_powerdown |=> !lowspeed_pll_active)
        else $error("pll on in global powerdown");
    pin_off_a: assert property (!transceiver_powerdown_n [*5] |-> !lowspeed_pll_active)
        else $error("pll on with pin low");
    mpy_flag_a: assert property (multiplier_reserved ==
        (lowspeed_pll_multiplier inside {4'h3, 4'hb, 4'hc, 4'hf})) else $error("flag wrong");
    cfg_hold_a: assert property (!wr_any [*2] |=>
        $stable({lowspeed_pll_loop_bw, lowspeed_pll_multiplier})) else $error("cfg moved");
    lane_hold_a: assert property (!wr_any [*2] |=> $stable(lane_b_values))
        else $error("lane copy moved");
endmodule : lspl_lane_cfg_chk
bind lspl_lane_cfg lspl_lane_cfg_chk #(.LANES(LANES)) i_lspl_lane_cfg_chk (
    .clock(clock), .resetn(resetn), .req_valid(req_valid), .req(req), .req_dev(req_dev),
    .transceiver_powerdown_n(transceiver_powerdown_n), .global_powerdown(global_powerdown),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .lowspeed_pll_active(lowspeed_pll_active),
    .lowspeed_pll_loop_bw(lowspeed_pll_loop_bw), .lane_b_values(lane_b_values),
    .lowspeed_pll_multiplier(lowspeed_pll_multiplier), .multiplier_reserved(multiplier_reserved));
`default_nettype wire

/* test/lspl_ctrl_model.sv */
// Management controller model issuing requests
`timescale 1ns/100ps
`default_nettype none
module lspl_ctrl_model (
    input wire logic clock,
    output logic req_valid,
    output lspl_pkg::lspl_req_t req,
    output logic [4:0] req_dev
);
    initial begin
        req_valid = 1'b0;
        req = '0;
        req_dev = 5'h1e;
    end
    task send(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [4:0] v);
        req_valid = 1'b1;
        req = {w, a, d};
        req_dev = v;
        @(posedge clock);
        #1;
    endtask : send
    task idle;
        req_valid = 1'b0;
        req = ~req;
        @(posedge clock);
        #1;
    endtask : idle
endmodule : lspl_ctrl_model
`default_nettype wire

/* test/lspl_lane_cfg_bench.sv */
// Self-checking bench for the lane configuration block
`timescale 1ns/100ps
`default_nettype none
module lspl_lane_cfg_bench;
    logic clock, resetn, tpd_n, gpd, req_valid, rsp_valid, pll_act, mres;
    lspl_pkg::lspl_req_t req;
    logic [4:0] req_dev;
    logic [15:0] rsp_rdata, x, d;
    logic [15:0] dv[3];
    logic [1:0] bw;
    logic [3:0] mpy;
    logic [63:0] lb, lc, la;
    logic [15:0] expq[$];
    int error_cnt, compares, cyc;
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    lspl_ctrl_model i_lspl_ctrl_model (.clock(clock), .req_valid(req_valid), .req(req),
        .req_dev(req_dev));
    lspl_lane_cfg i_lspl_lane_cfg (.clock(clock), .resetn(resetn), .req_valid(req_valid),
        .req(req), .req_dev(req_dev), .transceiver_powerdown_n(tpd_n), .global_powerdown(gpd),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .lowspeed_pll_active(pll_act),
        .lowspeed_pll_loop_bw(bw), .lowspeed_pll_multiplier(mpy), .multiplier_reserved(mres),
        .lane_b_values(lb), .lane_c_values(lc), .chan_a_values(la));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task rd(input logic [15:0] a, input logic [15:0] e);
        expq.push_back(e);
        i_lspl_ctrl_model.send(1'b0, a, 16'h0000, 5'h1e);
    endtask : rd
    task results;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    always @(posedge clock) begin
        cyc++;
        if (rsp_valid === 1'b1) begin
            chk("rdata", expq.pop_front(), rsp_rdata);
        end
        if (cyc == 3000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        resetn = 1'b0;
        tpd_n = 1'b1;
        gpd = 1'b0;
        x = 16'h0956;
        repeat (4) @(posedge clock);
        #1;
        resetn = 1'b1;
        rd(16'h0006, 16'hf115);
        i_lspl_ctrl_model.send(1'b1, 16'h0006, 16'h1115, 5'h1e);
        rd(16'h0007, 16'hdc04);
        rd(16'h0010, 16'h0000);
        i_lspl_ctrl_model.send(1'b0, 16'h0006, 16'h0000, 5'h1d);
        i_lspl_ctrl_model.idle();
        chk("bw", 16'h0001, {14'h0, bw});
        chk("mpy", 16'h0005, {12'h0, mpy});
        chk("pll", 16'h0001, {15'h0, pll_act});
        chk("mres0", 16'h0000, {15'h0, mres});
        i_lspl_ctrl_model.send(1'b1, 16'h0006, 16'h3ebb, 5'h1e);
        for (int a = 0; a < 3; a++) begin
            x = lfsr(x);
            dv[a] = x;
            i_lspl_ctrl_model.send(1'b1, 16'(7 + a), x, 5'h1e);
        end
        for (int n = 0; n < 4; n++) begin
            d = {4'h1 << n, 12'hebb};
            i_lspl_ctrl_model.send(1'b1, 16'h0006, d, 5'h1e);
            rd(16'h0006, d);
            for (int a = 0; a < 3; a++) begin
                rd(16'(7 + a), n < 2 ? dv[a] : (a == 0 ? 16'hdc04 : 16'h0000));
            end
        end
        i_lspl_ctrl_model.idle();
        chk("lane_b0", dv[0], lb[15:0]);
        chk("lane_b3", 16'hdc04, lb[63:48]);
        chk("lane_c1", dv[1], lc[31:16]);
        chk("chan_a0", dv[2], la[15:0]);
        chk("chan_a3", 16'h0000, la[63:48]);
        chk("pll_on", 16'h0001, {15'h0, pll_act});
        chk("bw_jc", 16'h0002, {14'h0, bw});
        chk("mpy_b", 16'h000b, {12'h0, mpy});
        chk("mres", 16'h0001, {15'h0, mres});
        gpd = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk("pll_gpd", 16'h0000, {15'h0, pll_act});
        gpd = 1'b0;
        tpd_n = 1'b0;
        repeat (5) @(posedge clock);
        #1;
        chk("pll_pin", 16'h0000, {15'h0, pll_act});
        tpd_n = 1'b1;
        repeat (5) @(posedge clock);
        #1;
        chk("pll_back", 16'h0001, {15'h0, pll_act});
        i_lspl_ctrl_model.send(1'b1, 16'h0006, 16'h1105, 5'h1e);
        i_lspl_ctrl_model.idle();
        chk("pll_off", 16'h0000, {15'h0, pll_act});
        chk("pending", 16'h0000, 16'(expq.size()));
        results();
    end
endmodule : lspl_lane_cfg_bench
`default_nettype wire
